// ===== design/irmod_pkg.sv
package irmod_pkg;
    // selector codes for the modulator's registers
    localparam logic [2:0] SEL_ON_DURATION  = 3'h0;
    localparam logic [2:0] SEL_OFF_DURATION = 3'h1;
    localparam logic [2:0] SEL_COUNT_LOW    = 3'h2;
    localparam logic [2:0] SEL_CONTROL      = 3'h3;
    localparam logic [2:0] SEL_COUNT_HIGH   = 3'h4;

    // modulator_control field positions
    localparam int CTRL_CARRIER_ENABLE   = 0;
    localparam int CTRL_LONG_PULSE_MODE  = 1;
    localparam int CTRL_CONTINUOUS_TRAIN = 2;
    localparam int CTRL_IRQ_CLEAR        = 3;
    localparam int CTRL_WATCHDOG_RELOAD  = 4;
    localparam int CTRL_STORED_BITS      = 3;
    localparam logic [2:0] CTRL_RESET    = 3'h0;

    // widths and reset values
    localparam int DATA_W                = 8;
    localparam int COUNT_W               = 10;
    localparam int TIMER_W               = 9;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [9:0] COUNT_RESET   = 10'h000;
    localparam logic [8:0] TIMER_EXTRA   = 9'h001; // timer loads value+1, counts to 0: value+2 cycles
    localparam logic [1:0] CARRIER_START = 2'h0;

    // derivative transfer instructions
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_READ  = 2'h1,
        OP_AND   = 2'h2,
        OP_OR    = 2'h3
    } deriv_op_t;

    // controller's own register map (software side of the core end)
    localparam logic [1:0] HOST_ACC    = 2'h0;
    localparam logic [1:0] HOST_CMD    = 2'h1;
    localparam logic [1:0] HOST_STATUS = 2'h2;
    localparam int HOST_CMD_OP_LSB     = 0;
    localparam int HOST_CMD_SEL_LSB    = 2;
    localparam int HOST_ST_IRQ         = 0;
    localparam int HOST_ST_BUSY        = 1;
endpackage : irmod_pkg

// ===== design/deriv_if.sv
`timescale 1ns/1ps
interface deriv_if;
    logic                 req;   // one-cycle instruction strobe
    irmod_pkg::deriv_op_t op;    // instruction kind
    logic [2:0]           sel;   // derivative_reg_select
    logic [7:0]           acc;   // accumulator value
    logic [7:0]           rdata; // register value, cycle after a read
    logic                 irq;   // completion interrupt level

    modport core (output req, output op, output sel, output acc, input rdata, input irq);
    modport modulator (input req, input op, input sel, input acc, output rdata, output irq);
endinterface : deriv_if

// ===== design/ir_pulse_burst_modulator.sv
// Operation
// - on register 00H: active value+2 cycles
// - off register 01H: inactive value+2 cycles
// - control bit 4 pulses watchdog clear
// - control bit 3 clears completion interrupt
// - bit 2: endless train, count ignored
// - bit 1: one pulse on times count
// - long pulse with carrier is modulated throughout
// - bit 0: quarter-clock carrier on active part
// - control bits 7..5 reserved, no function
// - write instruction stores accumulator into register
// - read instruction returns selected register
// - AND instruction: register AND accumulator stored
// - OR instruction: register OR accumulator stored
// - output high after reset
// - pulse train on one active-low pin
// - 10-bit count at 02H/04H, never zero
// - count load starts burst, on timer counts
// - each pulse end decrements, off then on
// - count zero raises interrupt; load/clear drops it
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module ir_pulse_burst_modulator (
    input  wire logic     CLK_SYS,
    input  wire logic     RST_N,
    deriv_if.modulator    DERIV,
    output logic          OUT_N,
    output logic          WDT_CLEAR
);

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_ON   = 3'b010,
        S_OFF  = 3'b100
    } mod_state_t;

    logic [7:0]   on_q;
    logic [7:0]   off_q;
    logic [1:0]   hi_q;
    logic [9:0]   cnt_q;
    logic [9:0]   cnt_d;
    logic [2:0]   ctrl_q;
    logic [8:0]   timer_q;
    logic [8:0]   timer_d;
    logic [1:0]   phase_q;
    logic [1:0]   phase_d;
    mod_state_t   state_q;
    mod_state_t   state_d;
    logic         irq_q;
    logic [7:0]   rdata_q;
    logic [7:0]   cur_val;
    logic [7:0]   wr_val;
    logic         wr_en;
    logic         cnt_load;
    logic [9:0]   load_val;
    logic         burst_done;
    logic         carrier_low;

    // current contents of the selected register, as a read would see them
    always_comb begin
        case (DERIV.sel)
            irmod_pkg::SEL_ON_DURATION:  cur_val = on_q;
            irmod_pkg::SEL_OFF_DURATION: cur_val = off_q;
            irmod_pkg::SEL_COUNT_LOW:    cur_val = cnt_q[7:0];
            irmod_pkg::SEL_COUNT_HIGH:   cur_val = {6'h00, hi_q};
            irmod_pkg::SEL_CONTROL:      cur_val = {5'h00, ctrl_q};
            default:                     cur_val = 8'h00;
        endcase
    end

    // value a store instruction writes back; and/or act on the visible value
    always_comb begin
        case (DERIV.op)
            irmod_pkg::OP_AND: wr_val = cur_val & DERIV.acc;
            irmod_pkg::OP_OR:  wr_val = cur_val | DERIV.acc;
            default:           wr_val = DERIV.acc;
        endcase
    end

    assign wr_en    = DERIV.req && (DERIV.op != irmod_pkg::OP_READ);
    assign cnt_load = wr_en && (DERIV.sel == irmod_pkg::SEL_COUNT_LOW);
    // the high part must already be in place; a low-byte store launches the burst
    assign load_val = {hi_q, wr_val};

    // on, off and high-count storage
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            on_q  <= irmod_pkg::REG_RESET;
            off_q <= irmod_pkg::REG_RESET;
            hi_q  <= 2'h0;
        end else if (wr_en) begin
            if (DERIV.sel == irmod_pkg::SEL_ON_DURATION) begin
                on_q <= wr_val;
            end
            if (DERIV.sel == irmod_pkg::SEL_OFF_DURATION) begin
                off_q <= wr_val;
            end
            if (DERIV.sel == irmod_pkg::SEL_COUNT_HIGH) begin
                hi_q <= wr_val[1:0];
            end
        end
    end

    // control: only the three mode bits are kept, upper bits are not stored
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ctrl_q <= irmod_pkg::CTRL_RESET;
        end else if (wr_en && DERIV.sel == irmod_pkg::SEL_CONTROL) begin
            ctrl_q <= wr_val[irmod_pkg::CTRL_STORED_BITS-1:0];
        end
    end

    // watchdog clear leaves as a one-cycle pulse, not stored
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            WDT_CLEAR <= 1'b0;
        end else begin
            WDT_CLEAR <= wr_en && DERIV.sel == irmod_pkg::SEL_CONTROL
                         && wr_val[irmod_pkg::CTRL_WATCHDOG_RELOAD];
        end
    end

    // read data stands in the cycle after the read only
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else if (DERIV.req && DERIV.op == irmod_pkg::OP_READ) begin
            rdata_q <= cur_val;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // pulse engine next state
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        timer_d    = (timer_q != 9'h000) ? 9'(timer_q - 9'h001) : timer_q;
        phase_d    = 2'(phase_q + 2'h1);
        burst_done = 1'b0;
        if (cnt_load) begin
            if (load_val != irmod_pkg::COUNT_RESET) begin
                // restart from scratch even mid-burst
                state_d = S_ON;
                cnt_d   = load_val;
                timer_d = 9'({1'b0, on_q} + irmod_pkg::TIMER_EXTRA);
                phase_d = irmod_pkg::CARRIER_START;
            end else begin
                // zero is illegal: stop quietly rather than run 1024 pulses
                state_d = S_IDLE;
                cnt_d   = irmod_pkg::COUNT_RESET;
            end
        end else begin
            case (state_q)
                S_ON: begin
                    if (timer_q == 9'h000) begin
                        if (!ctrl_q[irmod_pkg::CTRL_CONTINUOUS_TRAIN]) begin
                            cnt_d = 10'(cnt_q - 10'h001);
                        end
                        if (!ctrl_q[irmod_pkg::CTRL_CONTINUOUS_TRAIN] && cnt_q == 10'h001) begin
                            state_d    = S_IDLE;
                            burst_done = 1'b1;
                        end else if (ctrl_q[irmod_pkg::CTRL_LONG_PULSE_MODE]) begin
                            // stay active, carrier keeps running across the join
                            timer_d = 9'({1'b0, on_q} + irmod_pkg::TIMER_EXTRA);
                        end else begin
                            state_d = S_OFF;
                            timer_d = 9'({1'b0, off_q} + irmod_pkg::TIMER_EXTRA);
                        end
                    end
                end
                S_OFF: begin
                    if (timer_q == 9'h000) begin
                        state_d = S_ON;
                        timer_d = 9'({1'b0, on_q} + irmod_pkg::TIMER_EXTRA);
                        phase_d = irmod_pkg::CARRIER_START;
                    end
                end
                S_IDLE: begin
                    timer_d = 9'h000;
                end
                default: begin
                    state_d = S_IDLE;
                end
            endcase
        end
    end

    // engine registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            cnt_q   <= irmod_pkg::COUNT_RESET;
            timer_q <= 9'h000;
            phase_q <= irmod_pkg::CARRIER_START;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            timer_q <= timer_d;
            phase_q <= phase_d;
        end
    end

    // carrier: phases 0,1 active and 2,3 released, i.e. a quarter of the clock
    assign carrier_low = ctrl_q[irmod_pkg::CTRL_CARRIER_ENABLE] && phase_d[1];

    // output pin taken from a flop so it never glitches
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            OUT_N <= 1'b1;
        end else begin
            OUT_N <= !(state_d == S_ON && !carrier_low);
        end
    end

    // completion flag: the burst end outranks a same-cycle clear
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            irq_q <= 1'b0;
        end else if (burst_done) begin
            irq_q <= 1'b1;
        end else if (cnt_load || (wr_en && DERIV.sel == irmod_pkg::SEL_CONTROL
                                  && wr_val[irmod_pkg::CTRL_IRQ_CLEAR])) begin
            irq_q <= 1'b0;
        end
    end

    assign DERIV.rdata = rdata_q;
    assign DERIV.irq   = irq_q;

endmodule : ir_pulse_burst_modulator

// ===== design/deriv_core_port.sv
`timescale 1ns/1ps
module deriv_core_port (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic [1:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic [7:0]      RDATA,
    deriv_if.core           DERIV
);

    logic                 req_q;
    irmod_pkg::deriv_op_t op_q;
    logic [2:0]           sel_q;
    logic [7:0]           acc_q;
    logic                 pend_q;
    logic                 busy;

    // a read answer arrives the cycle after the strobe, so two cycles busy
    assign busy = req_q || pend_q;

    // instruction issue: one strobe per command write, refused while busy
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            req_q <= 1'b0;
            op_q  <= irmod_pkg::OP_WRITE;
            sel_q <= irmod_pkg::SEL_ON_DURATION;
        end else if (WR && ADDR == irmod_pkg::HOST_CMD && !busy) begin
            req_q <= 1'b1;
            op_q  <= irmod_pkg::deriv_op_t'(WDATA[irmod_pkg::HOST_CMD_OP_LSB +: 2]);
            sel_q <= WDATA[irmod_pkg::HOST_CMD_SEL_LSB +: 3];
        end else begin
            req_q <= 1'b0;
        end
    end

    // pending read tracker
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= req_q && op_q == irmod_pkg::OP_READ;
        end
    end

    // accumulator: returned data outranks a software write in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            acc_q <= 8'h00;
        end else if (pend_q) begin
            acc_q <= DERIV.rdata;
        end else if (WR && ADDR == irmod_pkg::HOST_ACC) begin
            acc_q <= WDATA;
        end
    end

    // software read port, data in the following cycle
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                irmod_pkg::HOST_ACC:    RDATA <= acc_q;
                irmod_pkg::HOST_CMD:    RDATA <= {3'h0, sel_q, op_q};
                irmod_pkg::HOST_STATUS: RDATA <= {6'h00, busy, DERIV.irq};
                default:                RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    assign DERIV.req = req_q;
    assign DERIV.op  = op_q;
    assign DERIV.sel = sel_q;
    assign DERIV.acc = acc_q;

endmodule : deriv_core_port

// ===== verification/ir_pulse_burst_modulator_monitor.sv
`timescale 1ns/1ps
module ir_pulse_burst_modulator_monitor (
    input wire logic                 CLK_SYS,
    input wire logic                 RST_N,
    input wire logic                 req,
    input wire irmod_pkg::deriv_op_t op,
    input wire logic [2:0]           sel,
    input wire logic [7:0]           acc,
    input wire logic [7:0]           rdata,
    input wire logic                 irq,
    input wire logic                 OUT_N,
    input wire logic                 WDT_CLEAR
);
    logic rd_req;
    logic wr_ctrl;
    logic wr_low;
    logic wdt_cause;
    logic ctrl_store;
    logic carrier_q;
    // decoded instructions on the link; write-only bits read 0, so only write and or can set them
    assign rd_req     = req && op == irmod_pkg::OP_READ;
    assign ctrl_store = req && op != irmod_pkg::OP_READ && sel == irmod_pkg::SEL_CONTROL;
    assign wr_ctrl    = ctrl_store && op != irmod_pkg::OP_AND;
    assign wr_low     = req && op != irmod_pkg::OP_READ && sel == irmod_pkg::SEL_COUNT_LOW;
    assign wdt_cause  = wr_ctrl && acc[irmod_pkg::CTRL_WATCHDOG_RELOAD];

    // carrier bit as last stored; the carrier chops active runs, so run checks need it
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            carrier_q <= 1'b0;
        end else if (ctrl_store) begin
            case (op)
                irmod_pkg::OP_AND: carrier_q <= carrier_q & acc[irmod_pkg::CTRL_CARRIER_ENABLE];
                irmod_pkg::OP_OR:  carrier_q <= carrier_q | acc[irmod_pkg::CTRL_CARRIER_ENABLE];
                default:           carrier_q <= acc[irmod_pkg::CTRL_CARRIER_ENABLE];
            endcase
        end
    end

    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    a_reset_idle: assert property ($rose(RST_N) |-> OUT_N && !irq && !WDT_CLEAR && rdata == 8'h00)
        else $error("outputs not idle after reset");
    a_wdt_pulse: assert property (wdt_cause |=> WDT_CLEAR ##1 !WDT_CLEAR)
        else $error("watchdog clear pulse wrong");
    a_wdt_cause: assert property (WDT_CLEAR |-> $past(wdt_cause))
        else $error("watchdog clear without cause");
    a_rdata_quiet: assert property (rdata != 8'h00 |-> $past(rd_req))
        else $error("read data outside read slot");
    a_ctrl_read: assert property (rd_req && sel == irmod_pkg::SEL_CONTROL |=> rdata[7:3] == 5'h00)
        else $error("control readback upper bits set");
    a_irq_clear: assert property (wr_ctrl && acc[irmod_pkg::CTRL_IRQ_CLEAR] && irq |=> !irq)
        else $error("interrupt not cleared");
    a_load_clears: assert property (wr_low |=> !irq)
        else $error("interrupt survives count load");
    a_irq_holds: assert property (irq && !wr_low && !(wr_ctrl && acc[irmod_pkg::CTRL_IRQ_CLEAR]) |=> irq)
        else $error("interrupt dropped by itself");
    a_idle_high: assert property (irq |-> OUT_N)
        else $error("output active while complete");
    a_burst_start: assert property (wr_low && op == irmod_pkg::OP_WRITE && acc != 8'h00 |=> !OUT_N [*2])
        else $error("burst did not start");
    a_low_min: assert property ($fell(OUT_N) && !carrier_q |=> !OUT_N)
        else $error("active run shorter than two");
    a_carrier_run: assert property (carrier_q && !OUT_N && !$past(OUT_N) |=> OUT_N)
        else $error("carrier low run longer than two");
    a_high_min: assert property ($rose(OUT_N) |=> OUT_N)
        else $error("inactive run shorter than two");
endmodule : ir_pulse_burst_modulator_monitor

// ===== verification/ir_pulse_burst_modulator_bench.sv
`timescale 1ns/1ps
module ir_pulse_burst_modulator_bench;
    logic       CLK_SYS;
    logic       RST_N;
    logic [1:0] ADDR;
    logic [7:0] WDATA;
    logic       WR;
    logic       RD;
    logic [7:0] RDATA;
    logic       OUT_N;
    logic       WDT_CLEAR;
    int         fails;
    int         checked;
    logic [7:0] mdl [0:4];

    deriv_if link();
    deriv_core_port i_deriv_core_port (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .DERIV(link.core));
    ir_pulse_burst_modulator i_ir_pulse_burst_modulator (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .DERIV(link.modulator), .OUT_N(OUT_N), .WDT_CLEAR(WDT_CLEAR));
    ir_pulse_burst_modulator_monitor i_ir_pulse_burst_modulator_monitor (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .req(link.req), .op(link.op), .sel(link.sel), .acc(link.acc), .rdata(link.rdata),
        .irq(link.irq), .OUT_N(OUT_N), .WDT_CLEAR(WDT_CLEAR));

    // 10 MHz system clock
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // software port cycles; a gap edge keeps strobes from being set twice in one step
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        @(negedge CLK_SYS);
        d = RDATA;
    endtask : rd

    task automatic dev(input logic [1:0] op, input logic [2:0] sel, input logic [7:0] a);
        wr(irmod_pkg::HOST_ACC, a);
        wr(irmod_pkg::HOST_CMD, {3'h0, sel, op});
    endtask : dev

    // read instruction, then fetch the accumulator once the answer has landed
    task automatic devrd(input logic [2:0] sel, output logic [7:0] d);
        dev(2'h1, sel, 8'h00);
        repeat (3) @(posedge CLK_SYS);
        rd(irmod_pkg::HOST_ACC, d);
    endtask : devrd

    // expected output built cycle by cycle from the mode bits
    task automatic burst(input logic [2:0] c, input logic [7:0] on, input logic [7:0] off, input logic [9:0] n);
        logic e [$];
        int   k;
        logic [7:0] st;
        dev(2'h0, irmod_pkg::SEL_CONTROL, {5'h00, c});
        dev(2'h0, irmod_pkg::SEL_ON_DURATION, on);
        dev(2'h0, irmod_pkg::SEL_OFF_DURATION, off);
        dev(2'h0, irmod_pkg::SEL_COUNT_HIGH, {6'h00, n[9:8]});
        k = 0;
        for (int p = 0; p < n; p++) begin
            if (!c[1]) k = 0;
            for (int j = 0; j < on + 2; j++) begin
                e.push_back(c[0] && (k % 4 >= 2));
                k++;
            end
            if (!c[1] && (c[2] || p < n - 1)) repeat (off + 2) e.push_back(1'b1);
        end
        if (!c[2]) repeat (4) e.push_back(1'b1);
        dev(2'h0, irmod_pkg::SEL_COUNT_LOW, n[7:0]);
        @(posedge CLK_SYS);
        foreach (e[i]) begin
            @(negedge CLK_SYS);
            check({9'h0, OUT_N}, {9'h0, e[i]});
        end
        check({9'h0, link.irq}, {9'h0, !c[2]});
        // status: interrupt as above, engine port no longer busy
        rd(irmod_pkg::HOST_STATUS, st);
        check({8'h0, st[1:0]}, {9'h0, !c[2]});
        if (c[2]) dev(2'h0, irmod_pkg::SEL_COUNT_LOW, 8'h00);
        else dev(2'h0, irmod_pkg::SEL_CONTROL, 8'h08);
    endtask : burst

    task automatic summarize();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // main sequence: reset values, register transfers, then pulse modes 0 to 4
    initial begin
        logic [7:0] d;
        logic [7:0] a;
        logic [7:0] cur;
        logic [1:0] op;
        logic [2:0] s;
        fails   = 0;
        checked = 0;
        RST_N   = 1'b0;
        ADDR    = 2'h0;
        WDATA   = 8'h00;
        WR      = 1'b0;
        RD      = 1'b0;
        foreach (mdl[i]) mdl[i] = 8'h00;
        void'($urandom(32'h5A92));
        repeat (16) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(negedge CLK_SYS);
        check({9'h0, OUT_N}, 10'h001);
        for (int i = 0; i < 5; i++) begin
            devrd(3'(i), d);
            check({2'h0, d}, 10'h000);
        end
        rd(2'h3, d);
        check({2'h0, d}, 10'h000);
        // random write, read, and and or on every register except the burst trigger
        for (int i = 0; i < 40; i++) begin
            op  = 2'($urandom_range(3));
            s   = 3'($urandom_range(4));
            s   = (s == irmod_pkg::SEL_COUNT_LOW) ? irmod_pkg::SEL_CONTROL : s;
            a   = 8'($urandom);
            cur = mdl[s];
            dev(op, s, a);
            if (op == 2'h0) mdl[s] = a;
            else if (op == 2'h2) mdl[s] = cur & a;
            else if (op == 2'h3) mdl[s] = cur | a;
            mdl[3] = mdl[3] & 8'h07;
            mdl[4] = mdl[4] & 8'h03;
            devrd(s, d);
            check({2'h0, d}, {2'h0, mdl[s]});
        end
        // watchdog clear: one pulse in the cycle after the control store, then gone
        dev(2'h0, irmod_pkg::SEL_CONTROL, 8'h10);
        @(negedge CLK_SYS);
        @(negedge CLK_SYS);
        check({9'h0, WDT_CLEAR}, 10'h001);
        @(negedge CLK_SYS);
        check({9'h0, WDT_CLEAR}, 10'h000);
        for (int c = 0; c < 5; c++) begin
            burst(3'(c), 8'($urandom_range(6)), 8'($urandom_range(6)), 10'($urandom_range(3, 1)));
        end
        burst(3'h0, 8'h00, 8'h01, 10'h101);
        burst(3'h1, 8'hFF, 8'h00, 10'h002);
        summarize();
    end
endmodule : ir_pulse_burst_modulator_bench
